// ==== core/ddp_pkg.sv ====
/*
 * Shared constants, command and state types for the DDR pin command
 * interface. Assumes it is compiled before every design file.
 */
package ddp_pkg;

    localparam int ADDR_W  = 14;
    localparam int BA_W    = 2;
    localparam int NBANK   = 4;
    localparam int DQ_W    = 16;
    localparam int LANES   = 2;
    localparam int BYTE_W  = 8;
    localparam int AP_BIT  = 10;
    localparam int SYNC_ST = 2;

    localparam logic [ADDR_W-1:0] MODE_RST  = 14'h0000;
    localparam logic [BA_W-1:0]   BA_MR     = 2'h0;
    localparam logic [BA_W-1:0]   BA_EMR    = 2'h1;
    localparam logic [NBANK-1:0]  OPEN_RST  = 4'h0;
    localparam logic [DQ_W-1:0]   DQ_RST    = 16'h0000;

    // Per-lane write phases: idle, waiting rising strobe, waiting falling.
    localparam logic [1:0] WPH_IDLE = 2'h0;
    localparam logic [1:0] WPH_RISE = 2'h1;
    localparam logic [1:0] WPH_FALL = 2'h2;

    // Codes are {cs_n, ras_n, cas_n, we_n}; any code with cs_n high
    // is folded onto CMD_DESEL.
    typedef enum logic [3:0] {
        CMD_LMR   = 4'h0,
        CMD_REF   = 4'h1,
        CMD_PRE   = 4'h2,
        CMD_ACT   = 4'h3,
        CMD_WR    = 4'h4,
        CMD_RD    = 4'h5,
        CMD_BST   = 4'h6,
        CMD_NOP   = 4'h7,
        CMD_DESEL = 4'h8
    } ddp_cmd_t;

    typedef enum logic [1:0] {
        PS_ACTIVE,
        PS_PRE_PD,
        PS_ACT_PD,
        PS_SELF_REF
    } ddp_pwr_t;

    typedef enum logic [1:0] {
        RD_IDLE,
        RD_WAIT,
        RD_HI,
        RD_LO
    } ddp_rd_t;

    function automatic ddp_cmd_t ddp_decode(input logic [3:0] code);
        ddp_cmd_t c;
        c = CMD_DESEL;
        if (!code[3]) begin
            c = ddp_cmd_t'(code);
        end
        return c;
    endfunction : ddp_decode

endpackage : ddp_pkg

// ==== core/ddp_mem.sv ====
/*
 * Small byte-enabled storage array with a registered read port.
 * Assumes one write and one read address per clock, same clock.
 */
`timescale 1ns/100ps
module ddp_mem #(
    parameter int AW = 6,
    parameter int DW = 32
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic [DW/8-1:0] be_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [DW-1:0] wdata_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic      [DW-1:0] rdata_o
);

    logic [DW-1:0] mem [2**AW];

    // One process owns the whole array, because a process per byte lane
    // would give the array several drivers.
    always_ff @(posedge clk_i) begin
        for (int b = 0; b < DW/8; b++) begin
            if (be_i[b]) begin
                mem[waddr_i][b*8 +: 8] <= wdata_i[b*8 +: 8];
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= mem[raddr_i];
        end
    end

endmodule : ddp_mem

// ==== core/ddp_dram_pins.sv ====
/*
 * Device-side pin logic of a four-bank double-data-rate DRAM: command
 * sampling on CK crossings, bank and mode state, power states, masked
 * write capture on DQS and edge-aligned read launch. Assumes all pins
 * are asynchronous to ref_clk_i, which runs much faster than CK.
 */
// Summary of operation
// - ACTIVE takes row; READ/WRITE take column and A10 auto-precharge.
// - PRECHARGE closes addressed bank if A10 low, all banks if high.
// - Mode register load stores the address-bus operation code.
// - ACTIVE, READ, WRITE, single PRECHARGE act on the addressed bank.
// - Bank address picks base or extended mode register on load.
// - Address and control sampled only at the CK rising crossing.
// - Read data and strobe change at CK crossings.
// - CKE high keeps clock, inputs, outputs alive; low shuts them.
// - CKE low: idle means precharge PD or self refresh, else active PD.
// - PD entry, exit and self-refresh entry synchronous; its exit async.
// - Power-down keeps only CK and CKE; self refresh keeps only CKE.
// - Chip select low enables decoding; high masks every command.
// - Command decoded from chip select, row, column and write strobes.
// - Write data byte with mask high is not stored.
// - Mask sampled on both strobe edges with its data word.
// - Lower mask guards low byte, upper mask guards high byte.
// - Read strobe edge-aligned; write strobe arrives centre-aligned.
`timescale 1ns/100ps
module ddp_dram_pins
    import ddp_pkg::*;
#(
    parameter int ROW_BITS = 2,
    parameter int COL_BITS = 3
) (
    input  wire logic              ref_clk_i,
    input  wire logic              rst_i,
    input  wire logic              ck_i,
    input  wire logic              ck_n_i,
    input  wire logic              cke_i,
    input  wire logic              cs_n_i,
    input  wire logic              ras_n_i,
    input  wire logic              cas_n_i,
    input  wire logic              we_n_i,
    input  wire logic [BA_W-1:0]   ba_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [LANES-1:0]  dm_i,
    input  wire logic [DQ_W-1:0]   dq_i,
    input  wire logic [LANES-1:0]  dqs_i,
    output logic      [DQ_W-1:0]   dq_o,
    output logic                   dq_oe_o,
    output logic      [LANES-1:0]  dqs_o,
    output logic                   dqs_oe_o,
    output logic      [ADDR_W-1:0] mode_reg_o,
    output logic      [ADDR_W-1:0] ext_mode_reg_o,
    output logic      [NBANK-1:0]  bank_open_o,
    output logic      [1:0]        pwr_state_o
);

    localparam int PIN_W = 7 + BA_W + ADDR_W + 2*LANES + DQ_W;
    localparam int AW    = BA_W + ROW_BITS + COL_BITS - 1;

    logic [PIN_W-1:0]    sync1_r;
    logic [PIN_W-1:0]    sync2_r;
    logic                ck_s, ck_n_s, cke_s;
    logic [3:0]          code_s;
    logic [BA_W-1:0]     ba_s;
    logic [ADDR_W-1:0]   addr_s;
    logic [LANES-1:0]    dm_s, dqs_s, dqs_prev_r;
    logic [DQ_W-1:0]     dq_s;
    logic                pos_r, ck_pos, ck_rise, ck_fall;
    ddp_cmd_t            cmd;
    logic                cmd_take;
    ddp_pwr_t            pwr_r;
    logic [NBANK-1:0]    open_r;
    logic [ROW_BITS-1:0] row_r [NBANK];
    ddp_rd_t             rd_st;
    logic [AW-1:0]       rd_addr_r, wr_addr_r, col_addr;
    logic [BA_W-1:0]     rd_bank_r, wr_bank_r;
    logic                rd_ap_r, wr_ap_r, drive_r;
    logic                rd_done, rd_close, rd_load;
    logic [2*DQ_W-1:0]   rdata;
    logic [DQ_W-1:0]     rd_lo_word;
    logic [1:0]          wph_r [LANES];
    logic [LANES-1:0]    dqs_rise, dqs_fall;
    logic [2*LANES-1:0]  be;
    logic                wr_busy, wr_busy_r, wr_close;

    // Every pin passes two flops; only the second stage is read.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {ck_i, ck_n_i, cke_i, cs_n_i, ras_n_i, cas_n_i,
                        we_n_i, ba_i, addr_i, dm_i, dq_i, dqs_i};
            sync2_r <= sync1_r;
        end
    end

    assign {ck_s, ck_n_s, cke_s, code_s, ba_s, addr_s, dm_s, dq_s,
            dqs_s} = sync2_r;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pos_r      <= 1'b0;
            dqs_prev_r <= '0;
        end else begin
            pos_r      <= ck_pos;
            dqs_prev_r <= dqs_s;
        end
    end

    assign ck_pos  = ck_s & ~ck_n_s;
    // clock buffer off in self refresh
    assign ck_rise = ck_pos & ~pos_r & (pwr_r != PS_SELF_REF);
    assign ck_fall = ~ck_pos & pos_r & (pwr_r != PS_SELF_REF);
    assign cmd      = ddp_decode(code_s);
    assign cmd_take = ck_rise & cke_s & (pwr_r == PS_ACTIVE) & ~code_s[3];

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pwr_r <= PS_ACTIVE;
        end else begin
            unique case (pwr_r)
                PS_ACTIVE: begin
                    if (ck_rise && !cke_s) begin
                        if (|open_r) begin
                            pwr_r <= PS_ACT_PD;
                        end else if (cmd == CMD_REF) begin
                            pwr_r <= PS_SELF_REF;
                        end else begin
                            pwr_r <= PS_PRE_PD;
                        end
                    end
                end
                PS_PRE_PD, PS_ACT_PD: begin
                    if (ck_rise && cke_s) begin
                        pwr_r <= PS_ACTIVE;
                    end
                end
                PS_SELF_REF: begin
                    if (cke_s) begin
                        pwr_r <= PS_ACTIVE;
                    end
                end
            endcase
        end
    end

    assign pwr_state_o = pwr_r;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_reg_o     <= MODE_RST;
            ext_mode_reg_o <= MODE_RST;
        end else if (cmd_take && cmd == CMD_LMR) begin
            if (ba_s == BA_MR) begin
                mode_reg_o <= addr_s;
            end else if (ba_s == BA_EMR) begin
                ext_mode_reg_o <= addr_s;
            end
        end
    end

    // Auto-precharge closes go first; a command to a bank still in a
    // burst is illegal, so the later assignment never hides one.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            open_r <= OPEN_RST;
            for (int i = 0; i < NBANK; i++) begin
                row_r[i] <= '0;
            end
        end else begin
            if (rd_close) begin
                open_r[rd_bank_r] <= 1'b0;
            end
            if (wr_close) begin
                open_r[wr_bank_r] <= 1'b0;
            end
            if (cmd_take && cmd == CMD_ACT) begin
                open_r[ba_s] <= 1'b1;
                row_r[ba_s]  <= addr_s[ROW_BITS-1:0];
            end else if (cmd_take && cmd == CMD_PRE) begin
                if (addr_s[AP_BIT]) begin
                    open_r <= OPEN_RST;
                end else begin
                    open_r[ba_s] <= 1'b0;
                end
            end
        end
    end

    assign bank_open_o = open_r;

    // bank, its open row and column pick the burst pair
    assign col_addr = {ba_s, row_r[ba_s], addr_s[COL_BITS-1:1]};
    assign rd_load  = cmd_take && cmd == CMD_RD;

    // a read abandoned if CKE is low at its launching CK rise
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_st     <= RD_IDLE;
            rd_addr_r <= '0;
            rd_bank_r <= '0;
            rd_ap_r   <= 1'b0;
        end else if (pwr_r != PS_ACTIVE) begin
            rd_st <= RD_IDLE;
        end else begin
            if (rd_load) begin
                rd_addr_r <= col_addr;
                rd_bank_r <= ba_s;
                rd_ap_r   <= addr_s[AP_BIT];
            end
            unique case (rd_st)
                RD_IDLE: begin
                    if (rd_load) begin
                        rd_st <= RD_WAIT;
                    end
                end
                RD_WAIT: begin
                    if (ck_rise) begin
                        rd_st <= RD_HI;
                    end
                end
                RD_HI: begin
                    if (cmd_take && cmd == CMD_BST) begin
                        rd_st <= RD_IDLE;
                    end else if (ck_fall) begin
                        rd_st <= RD_LO;
                    end
                end
                RD_LO: begin
                    if (ck_rise) begin
                        rd_st <= rd_load ? RD_WAIT : RD_IDLE;
                    end
                end
            endcase
        end
    end

    assign rd_done    = (rd_st == RD_LO) && ck_rise && pwr_r == PS_ACTIVE;
    assign rd_close   = rd_done && rd_ap_r;
    assign rd_lo_word = rdata[DQ_W-1:0];

    // strobe toggles with each data word
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dq_o    <= DQ_RST;
            dqs_o   <= '0;
            drive_r <= 1'b0;
        end else if (pwr_r != PS_ACTIVE) begin
            drive_r <= 1'b0;
            dqs_o   <= '0;
        end else if (rd_st == RD_WAIT && ck_rise) begin
            dq_o    <= rd_lo_word;
            dqs_o   <= '1;
            drive_r <= 1'b1;
        end else if (rd_st == RD_HI && ck_fall) begin
            dq_o  <= rdata[2*DQ_W-1:DQ_W];
            dqs_o <= '0;
        end else if ((rd_st == RD_LO && ck_rise) ||
                     (rd_st == RD_HI && cmd_take && cmd == CMD_BST)) begin
            drive_r <= 1'b0;
            dqs_o   <= '0;
        end
    end

    // drivers follow CKE at once, without waiting for CK.
    assign dq_oe_o  = drive_r & cke_s;
    assign dqs_oe_o = drive_r & cke_s;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_addr_r <= '0;
            wr_bank_r <= '0;
            wr_ap_r   <= 1'b0;
            wr_busy_r <= 1'b0;
        end else begin
            wr_busy_r <= wr_busy;
            if (cmd_take && cmd == CMD_WR) begin
                wr_addr_r <= col_addr;
                wr_bank_r <= ba_s;
                wr_ap_r   <= addr_s[AP_BIT];
            end
        end
    end

    genvar l;
    generate
        for (l = 0; l < LANES; l++) begin : g_lane
            // strobe buffers off outside the active state
            assign dqs_rise[l] = dqs_s[l] & ~dqs_prev_r[l] &
                                 (pwr_r == PS_ACTIVE);
            assign dqs_fall[l] = ~dqs_s[l] & dqs_prev_r[l] &
                                 (pwr_r == PS_ACTIVE);
            always_ff @(posedge ref_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    wph_r[l] <= WPH_IDLE;
                end else if (cmd_take && cmd == CMD_WR) begin
                    wph_r[l] <= WPH_RISE;
                end else if (wph_r[l] == WPH_RISE && dqs_rise[l]) begin
                    wph_r[l] <= WPH_FALL;
                end else if (wph_r[l] == WPH_FALL && dqs_fall[l]) begin
                    wph_r[l] <= WPH_IDLE;
                end
            end
            assign be[l]       = (wph_r[l] == WPH_RISE) & dqs_rise[l] &
                                 ~dm_s[l];
            assign be[LANES+l] = (wph_r[l] == WPH_FALL) & dqs_fall[l] &
                                 ~dm_s[l];
        end
    endgenerate

    assign wr_busy  = (wph_r[0] != WPH_IDLE) | (wph_r[1] != WPH_IDLE);
    assign wr_close = wr_busy_r & ~wr_busy & wr_ap_r;

    ddp_mem #(
        .AW (AW),
        .DW (2*DQ_W)
    ) u_mem (
        .clk_i   (ref_clk_i),
        .rst_i   (rst_i),
        .be_i    (be),
        .waddr_i (wr_addr_r),
        .wdata_i ({dq_s, dq_s}),
        .raddr_i (rd_addr_r),
        .rdata_o (rdata)
    );

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    sequence rd_launch_s;
        rd_st == RD_WAIT && ck_rise && pwr_r == PS_ACTIVE;
    endsequence
    sequence rd_second_s;
        rd_st == RD_HI && ck_fall && pwr_r == PS_ACTIVE && !cmd_take;
    endsequence

    row_open_a: assert property (cmd_take && cmd == CMD_ACT
        |=> bank_open_o[$past(ba_s)])
        else $error("activated bank not open");
    pre_all_a: assert property (cmd_take && cmd == CMD_PRE
        && addr_s[AP_BIT] |=> bank_open_o == OPEN_RST)
        else $error("precharge all left a bank open");
    pre_one_a: assert property (cmd_take && cmd == CMD_PRE
        && !addr_s[AP_BIT] |=> !bank_open_o[$past(ba_s)])
        else $error("single precharge missed its bank");
    mode_load_a: assert property (cmd_take && cmd == CMD_LMR
        && ba_s == BA_MR |=> mode_reg_o == $past(addr_s))
        else $error("mode register not loaded");
    ext_load_a: assert property (cmd_take && cmd == CMD_LMR
        && ba_s == BA_EMR |=> ext_mode_reg_o == $past(addr_s)
        && $stable(mode_reg_o))
        else $error("extended mode register select wrong");
    sample_edge_a: assert property ($changed(mode_reg_o)
        |-> $past(ck_rise) && !$past(code_s[3]))
        else $error("mode changed off a CK rise");
    cs_mask_a: assert property (ck_rise && code_s[3]
        |=> $stable(mode_reg_o) && $stable(ext_mode_reg_o))
        else $error("deselected command acted");
    rd_edge_a: assert property (rd_launch_s ##1 1
        |-> dqs_o == '1 && dq_oe_o == cke_s && dq_o == $past(rd_lo_word))
        else $error("read first word not launched");
    rd_fall_a: assert property (rd_second_s |=> dqs_o == '0
        && drive_r)
        else $error("read second word strobe wrong");
    cke_off_a: assert property (!cke_s |-> !dq_oe_o && !dqs_oe_o)
        else $error("outputs driven with CKE low");
    act_pd_a: assert property (pwr_r == PS_ACTIVE && ck_rise
        && !cke_s && |open_r |=> pwr_r == PS_ACT_PD)
        else $error("active power-down not entered");
    sr_exit_a: assert property (pwr_r == PS_SELF_REF && cke_s
        |=> pwr_r == PS_ACTIVE)
        else $error("self refresh exit late");
    dm_mask_a: assert property (wph_r[1] == WPH_FALL
        && dqs_fall[1] && dm_s[1] |-> !be[3])
        else $error("upper mask ignored");
    wr_phase_a: assert property (wph_r[0] == WPH_RISE
        && dqs_rise[0] && !cmd_take |=> wph_r[0] == WPH_FALL)
        else $error("write lane missed strobe rise");

endmodule : ddp_dram_pins

// ==== dv/ddp_ctrl_model.sv ====
/*
 * Controller-side model facing the DRAM pin block: it makes CK and CKE,
 * sends commands and centre-aligned write bursts, and samples read data.
 * Assumes its tasks are called one at a time just after a clock edge.
 */
`timescale 1ns/100ps
module ddp_ctrl_model
    import ddp_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic [DQ_W-1:0]   rd_dq_i,
    input  wire logic [LANES-1:0]  rd_dqs_i,
    input  wire logic              rd_oe_i,
    output logic                   ck_o,
    output logic                   ck_n_o,
    output logic                   cke_o,
    output logic                   cs_n_o,
    output logic                   ras_n_o,
    output logic                   cas_n_o,
    output logic                   we_n_o,
    output logic      [BA_W-1:0]   ba_o,
    output logic      [ADDR_W-1:0] addr_o,
    output logic      [LANES-1:0]  dm_o,
    output logic      [DQ_W-1:0]   dq_o,
    output logic      [LANES-1:0]  dqs_o
);

    logic             wpend;
    logic             hi_oe;
    logic [LANES-1:0] wm0, wm1, hi_dqs, lo_dqs;
    logic [DQ_W-1:0]  wd0, wd1, hi_dq, lo_dq;

    initial begin
        ck_o = 1'b0;
        ck_n_o = 1'b1;
        cke_o = 1'b1;
        {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hF;
        ba_o = 2'h0;
        addr_o = 14'h0000;
        dm_o = 2'h0;
        dq_o = 16'h0000;
        dqs_o = 2'h0;
        wpend = 1'b0;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : wt

    task automatic set_cke(input logic v);
        cke_o = v;
    endtask : set_cke

    task automatic wdat(input logic [DQ_W-1:0] d0, d1,
                        input logic [LANES-1:0] m0, m1);
        {wd0, wd1, wm0, wm1} = {d0, d1, m0, m1};
        wpend = 1'b1;
    endtask : wdat

    // One CK period: the low half carries any pending burst, then CK rises.
    task automatic cyc(input logic [3:0] code, input logic [BA_W-1:0] ba,
                       input logic [ADDR_W-1:0] addr);
        {cs_n_o, ras_n_o, cas_n_o, we_n_o} = code;
        ba_o = ba;
        addr_o = addr;
        for (int i = 0; i < 16; i++) begin
            if (wpend && i % 8 == 0) begin
                dq_o = (i == 0) ? wd0 : wd1;
                dm_o = (i == 0) ? wm0 : wm1;
            end
            if (wpend && i % 8 == 4) begin
                dqs_o = (i == 4) ? 2'h3 : 2'h0;
            end
            if (i == 10) begin
                {lo_dq, lo_dqs} = {rd_dq_i, rd_dqs_i};
            end
            wt(1);
        end
        if (wpend) begin
            // Released lanes show the inverse so stale data cannot match.
            dq_o = ~wd1;
            dm_o = ~wm1;
            wpend = 1'b0;
        end
        ck_o = 1'b1;
        ck_n_o = 1'b0;
        wt(8);
        {hi_dq, hi_dqs, hi_oe} = {rd_dq_i, rd_dqs_i, rd_oe_i};
        wt(8);
        ck_o = 1'b0;
        ck_n_o = 1'b1;
    endtask : cyc

    task automatic nop();
        cyc(CMD_NOP, ~ba_o, ~addr_o);
    endtask : nop

endmodule : ddp_ctrl_model

// ==== dv/tb_ddp_dram_pins.sv ====
/*
 * Self-checking bench for the DRAM pin block with a controller model.
 * Assumes the package and both modules are compiled before this file.
 */
`timescale 1ns/100ps
module tb_ddp_dram_pins
    import ddp_pkg::*;
;
    logic              ref_clk, rst;
    logic              ck, ck_n, cke, cs_n, ras_n, cas_n, we_n;
    logic              dev_dq_oe, dev_dqs_oe;
    logic [BA_W-1:0]   ba, b;
    logic [ADDR_W-1:0] addr, mode_reg, ext_mode_reg, op, exp_mr, exp_emr;
    logic [LANES-1:0]  dm, ctrl_dqs, dev_dqs, dqs_bus, m0, m1;
    logic [DQ_W-1:0]   ctrl_dq, dev_dq, dq_bus, d0, d1, n0, n1;
    logic [NBANK-1:0]  bank_open, exp_open;
    logic [1:0]        pwr_state;
    logic [2:0]        col;
    int                mismatches, n_compared, seed;

    // The shared data and strobe wires go to whichever side drives them.
    assign dq_bus  = dev_dq_oe ? dev_dq : ctrl_dq;
    assign dqs_bus = dev_dqs_oe ? dev_dqs : ctrl_dqs;

    ddp_dram_pins u_ddp_dram_pins (
        .ref_clk_i(ref_clk), .rst_i(rst), .ck_i(ck), .ck_n_i(ck_n),
        .cke_i(cke), .cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n),
        .we_n_i(we_n), .ba_i(ba), .addr_i(addr), .dm_i(dm),
        .dq_i(dq_bus), .dqs_i(dqs_bus), .dq_o(dev_dq),
        .dq_oe_o(dev_dq_oe), .dqs_o(dev_dqs), .dqs_oe_o(dev_dqs_oe),
        .mode_reg_o(mode_reg), .ext_mode_reg_o(ext_mode_reg),
        .bank_open_o(bank_open), .pwr_state_o(pwr_state)
    );

    ddp_ctrl_model u_ddp_ctrl_model (
        .ref_clk_i(ref_clk), .rd_dq_i(dev_dq), .rd_dqs_i(dev_dqs),
        .rd_oe_i(dev_dq_oe), .ck_o(ck), .ck_n_o(ck_n), .cke_o(cke),
        .cs_n_o(cs_n), .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n),
        .ba_o(ba), .addr_o(addr), .dm_o(dm), .dq_o(ctrl_dq),
        .dqs_o(ctrl_dqs)
    );

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [DQ_W-1:0] merge(input logic [DQ_W-1:0] o,
        input logic [DQ_W-1:0] n, input logic [LANES-1:0] m);
        return {m[1] ? o[15:8] : n[15:8], m[0] ? o[7:0] : n[7:0]};
    endfunction : merge

    task automatic rd_chk(input logic [1:0] bk, input logic [2:0] c,
        input logic [15:0] e0, input logic [15:0] e1, input logic ap);
        u_ddp_ctrl_model.cyc(CMD_RD, bk, {3'h0, ap, 7'h00, c});
        u_ddp_ctrl_model.nop();
        check(u_ddp_ctrl_model.hi_dq, e0);
        check({u_ddp_ctrl_model.hi_dqs, u_ddp_ctrl_model.hi_oe},
              3'h7);
        // Both output enables must still stand while the burst runs.
        check({dev_dqs_oe, dev_dq_oe}, 2'h3);
        u_ddp_ctrl_model.nop();
        check(u_ddp_ctrl_model.lo_dq, e1);
        check({u_ddp_ctrl_model.lo_dqs, u_ddp_ctrl_model.hi_oe},
              3'h0);
    endtask : rd_chk

    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    // About 47 CK periods of traffic; some thirteen times that means a hang.
    initial begin
        #100000;
        mismatches++;
        end_of_test();
    end

    initial begin
        seed = 32'h9176;
        mismatches = 0;
        n_compared = 0;
        exp_mr = 14'h0000;
        exp_emr = 14'h0000;
        exp_open = 4'h0;
        rst = 1'b1;
        repeat (8) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        u_ddp_ctrl_model.wt(4);
        check(pwr_state, PS_ACTIVE);
        for (int i = 0; i < 4; i++) begin
            op = 14'($random(seed));
            exp_mr = (i == 0) ? op : exp_mr;
            exp_emr = (i == 1) ? op : exp_emr;
            u_ddp_ctrl_model.cyc(CMD_LMR, 2'(i), op);
            check(mode_reg, exp_mr);
            check(ext_mode_reg, exp_emr);
        end
        u_ddp_ctrl_model.cyc(CMD_ACT | 4'h8, 2'h1, 14'h0001);
        check(bank_open, exp_open);
        for (int i = 0; i < 4; i++) begin
            u_ddp_ctrl_model.cyc(CMD_ACT, 2'(i), 14'(i));
            exp_open[i] = 1'b1;
            check(bank_open, exp_open);
        end
        // Back-to-back writes, the second partly masked, then a read back.
        for (int k = 0; k < 4; k++) begin
            b = 2'($random(seed));
            col = 3'($random(seed)) & 3'h6;
            {d0, d1} = $random(seed);
            {n0, n1} = $random(seed);
            m0 = (k == 0) ? 2'h3 : (k == 1) ? 2'h1 : 2'($random(seed));
            m1 = (k == 0) ? 2'h0 : (k == 1) ? 2'h2 : 2'($random(seed));
            u_ddp_ctrl_model.cyc(CMD_WR, b, 14'(col));
            u_ddp_ctrl_model.wdat(d0, d1, 2'h0, 2'h0);
            u_ddp_ctrl_model.cyc(CMD_WR, b, 14'(col));
            u_ddp_ctrl_model.wdat(n0, n1, m0, m1);
            u_ddp_ctrl_model.nop();
            rd_chk(b, col, merge(d0, n0, m0), merge(d1, n1, m1), 1'b0);
        end
        // Dropping CKE under a read must silence the drivers at once.
        u_ddp_ctrl_model.cyc(CMD_RD, b, 14'(col));
        u_ddp_ctrl_model.set_cke(1'b0);
        u_ddp_ctrl_model.nop();
        check(u_ddp_ctrl_model.hi_oe, 1'b0);
        check(pwr_state, PS_ACT_PD);
        u_ddp_ctrl_model.cyc(CMD_PRE, 2'h0, 14'h0400);
        check(bank_open, exp_open);
        u_ddp_ctrl_model.set_cke(1'b1);
        u_ddp_ctrl_model.nop();
        check(pwr_state, PS_ACTIVE);
        rd_chk(b, col, merge(d0, n0, m0), merge(d1, n1, m1), 1'b1);
        exp_open[b] = 1'b0;
        check(bank_open, exp_open);
        u_ddp_ctrl_model.cyc(CMD_PRE, b + 2'h1, 14'h3BFF);
        exp_open[b + 2'h1] = 1'b0;
        check(bank_open, exp_open);
        u_ddp_ctrl_model.cyc(CMD_PRE, b, 14'h0400);
        check(bank_open, 4'h0);
        u_ddp_ctrl_model.set_cke(1'b0);
        u_ddp_ctrl_model.nop();
        check(pwr_state, PS_PRE_PD);
        u_ddp_ctrl_model.set_cke(1'b1);
        u_ddp_ctrl_model.nop();
        check(pwr_state, PS_ACTIVE);
        u_ddp_ctrl_model.set_cke(1'b0);
        u_ddp_ctrl_model.cyc(CMD_REF, 2'h0, 14'h0000);
        check(pwr_state, PS_SELF_REF);
        u_ddp_ctrl_model.cyc(CMD_ACT, 2'h0, 14'h0000);
        check(bank_open, 4'h0);
        // Self refresh is left with CK parked, on CKE alone.
        u_ddp_ctrl_model.set_cke(1'b1);
        u_ddp_ctrl_model.wt(6);
        check(pwr_state, PS_ACTIVE);
        u_ddp_ctrl_model.cyc(CMD_ACT, 2'h3, 14'h0002);
        check(bank_open, 4'h8);
        end_of_test();
    end

endmodule : tb_ddp_dram_pins
